// ==== src/regfile_pkg.sv ====
// Package with constants, types and operation codes for the core register file
package regfile_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
    localparam int unsigned ADDR_BITS = 16;
    localparam logic [2:0] STACK_PAIR_IDX = 3'h7;
    localparam int unsigned FLAG_MASK_BIT = 7;
    localparam int unsigned FLAG_USER1_BIT = 6;
    localparam int unsigned FLAG_HALF_BIT = 5;
    localparam int unsigned FLAG_USER0_BIT = 4;
    localparam int unsigned FLAG_NEG_BIT = 3;
    localparam int unsigned FLAG_ZERO_BIT = 2;
    localparam int unsigned FLAG_OVF_BIT = 1;
    localparam int unsigned FLAG_CARRY_BIT = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h80;
    localparam int unsigned MIN_STATES = 2;
    localparam int unsigned MAX_STATES = 4;

    typedef enum logic [3:0] {
        ALU_NONE = 4'h0, ALU_ADD = 4'h1, ALU_ADDX = 4'h2, ALU_SUB = 4'h3,
        ALU_SUBX = 4'h4, ALU_CMP = 4'h5, ALU_NEG = 4'h6, ALU_LOGIC = 4'h7,
        ALU_SHIFT = 4'h8, ALU_DAA = 4'h9, ALU_DAS = 4'ha, ALU_BITC = 4'hb
    } alu_op_t;

    typedef enum logic [2:0] {
        FLAG_OP_NONE = 3'h0, LOAD_FLAGS_OP = 3'h1, AND_FLAGS_OP = 3'h2,
        OR_FLAGS_OP = 3'h3, XOR_FLAGS_OP = 3'h4, RESTORE_FLAGS_OP = 3'h5
    } flag_op_t;

    typedef enum logic [1:0] {
        ACC_WORD = 2'h0, ACC_UPPER = 2'h1, ACC_LOWER = 2'h2
    } access_t;

    typedef enum logic [2:0] {
        ST_VEC = 3'b001, ST_RUN = 3'b010, ST_EXC = 3'b100
    } ctl_state_t;

    typedef struct packed {
        logic en;
        logic [2:0] pair;
        access_t size;
        logic [15:0] data;
    } gpr_write_t;

    typedef struct packed {
        logic en;
        alu_op_t op;
        logic word;
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] result;
        logic carry_in_bit;
        logic carry_valid;
    } alu_report_t;

    // Byte of a word pair as selected by access size
    function automatic logic [7:0] byte_sel(input logic [15:0] w, input access_t s);
        byte_sel = (s == ACC_UPPER) ? w[15:8] : w[7:0];
    endfunction

    function automatic logic [15:0] word_align(input logic [15:0] a);
        word_align = {a[15:1], 1'b0};
    endfunction
endpackage

// ==== src/gpr_bank.sv ====
// Sixteen byte registers organised as eight word pairs
`timescale 1ns/1ps
module gpr_bank
    import regfile_pkg::*;
(
    input wire logic clk,
    input wire gpr_write_t wr,
    input wire logic [2:0] rd_a_pair,
    input wire access_t rd_a_size,
    input wire logic [2:0] rd_b_pair,
    input wire access_t rd_b_size,
    input wire logic [2:0] addr_pair,
    output logic [15:0] rd_a_data,
    output logic [15:0] rd_b_data,
    output logic [15:0] addr_data,
    output logic [15:0] stack_top_pointer
);
    // No reset: contents are undefined after reset by design
    logic [7:0] upper_q [8];
    logic [7:0] lower_q [8];

    always_ff @(posedge clk)
    begin
        if (wr.en && wr.size != ACC_LOWER)
        begin
            upper_q[wr.pair] <= (wr.size == ACC_WORD) ? wr.data[15:8] : wr.data[7:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (wr.en && wr.size != ACC_UPPER)
        begin
            lower_q[wr.pair] <= wr.data[7:0];
        end
    end

    function automatic logic [15:0] rd(input logic [2:0] p, input access_t s);
        logic [15:0] w;
        w = {upper_q[p], lower_q[p]};
        rd = (s == ACC_WORD) ? w : {8'h00, byte_sel(w, s)};
    endfunction

    // Registered read data
    always_ff @(posedge clk)
    begin
        rd_a_data <= rd(rd_a_pair, rd_a_size);
        rd_b_data <= rd(rd_b_pair, rd_b_size);
        addr_data <= {upper_q[addr_pair], lower_q[addr_pair]};
        stack_top_pointer <= {upper_q[STACK_PAIR_IDX], lower_q[STACK_PAIR_IDX]};
    end
endmodule

// ==== src/cpu_register_file_flags.sv ====
// Register file, program counter and condition flags of the core
`timescale 1ns/1ps
module cpu_register_file_flags
    import regfile_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire gpr_write_t gpr_wr,
    input wire logic [2:0] rd_a_pair,
    input wire access_t rd_a_size,
    input wire logic [2:0] rd_b_pair,
    input wire access_t rd_b_size,
    input wire logic [2:0] addr_pair,
    input wire logic [15:0] vector_data,
    input wire logic vector_valid,
    input wire logic pc_load,
    input wire logic [15:0] pc_load_value,
    input wire logic pc_advance,
    input wire logic exception_start,
    input wire alu_report_t alu,
    input wire flag_op_t flag_op,
    input wire logic [7:0] flag_operand,
    input wire logic [15:0] flag_restore_word,
    input wire logic [3:0] branch_cond,
    output logic [15:0] rd_a_data,
    output logic [15:0] rd_b_data,
    output logic [15:0] addr_out,
    output logic [15:0] stack_top_pointer,
    output logic [15:0] instruction_pointer,
    output logic [15:0] vector_addr,
    output logic vector_req,
    output logic [7:0] condition_flags,
    output logic [15:0] flags_push_word,
    output logic interrupts_masked,
    output logic half_carry,
    output logic branch_taken
);
    ctl_state_t state_q;
    logic [15:0] pc_q;
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [15:0] addr_word;
    logic upd_h, upd_n, upd_z, upd_v, upd_c;
    logic new_h, new_n, new_z, new_v, new_c;
    logic [16:0] sum17;
    logic [12:0] low13;
    logic [4:0] low5;
    logic [8:0] sum9;
    logic [15:0] res;
    logic cin;
    logic is_sub;

    gpr_bank u_bank (
        .clk(clk),
        .wr(gpr_wr),
        .rd_a_pair(rd_a_pair),
        .rd_a_size(rd_a_size),
        .rd_b_pair(rd_b_pair),
        .rd_b_size(rd_b_size),
        .addr_pair(addr_pair),
        .rd_a_data(rd_a_data),
        .rd_b_data(rd_b_data),
        .addr_data(addr_word),
        .stack_top_pointer(stack_top_pointer)
    );

    // Sixteen address bits cover the whole 64 kbyte space
    assign addr_out = addr_word;

    // Reset sequence: fetch the vector, then run
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ST_VEC;
        end
        else
        begin
            unique case (state_q)
                ST_VEC: if (vector_valid) state_q <= ST_RUN;
                ST_RUN: if (exception_start) state_q <= ST_EXC;
                ST_EXC: state_q <= ST_RUN;
                default: state_q <= ST_VEC;
            endcase
        end
    end

    assign vector_req = (state_q == ST_VEC);
    assign vector_addr = RESET_VECTOR_ADDR;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pc_q <= 16'h0000;
        end
        else if (state_q == ST_VEC)
        begin
            if (vector_valid)
            begin
                pc_q <= word_align(vector_data);
            end
        end
        else if (pc_load)
        begin
            pc_q <= word_align(pc_load_value);
        end
        else if (pc_advance)
        begin
            pc_q <= word_align(pc_q + 16'h0002);
        end
    end

    assign instruction_pointer = pc_q;

    // Arithmetic flag derivation from operands and result
    always_comb
    begin
        res = alu.result;
        cin = alu.carry_in_bit;
        is_sub = (alu.op == ALU_SUB) || (alu.op == ALU_SUBX) || (alu.op == ALU_CMP)
            || (alu.op == ALU_NEG);
        low5 = 5'h00;
        low13 = 13'h0000;
        sum9 = 9'h000;
        sum17 = 17'h00000;
        upd_h = 1'b0;
        upd_n = 1'b0;
        upd_z = 1'b0;
        upd_v = 1'b0;
        upd_c = 1'b0;
        new_h = flags_q[FLAG_HALF_BIT];
        new_n = alu.word ? res[15] : res[7];
        new_z = alu.word ? (res == 16'h0000) : (res[7:0] == 8'h00);
        new_v = 1'b0;
        new_c = flags_q[FLAG_CARRY_BIT];
        unique case (alu.op)
            ALU_ADD, ALU_ADDX, ALU_SUB, ALU_SUBX, ALU_CMP, ALU_NEG:
            begin
                if (!alu.word)
                begin
                    // Borrow out of bit 3 taken from the nibble difference
                    if (is_sub)
                    begin
                        low5 = {1'b0, alu.a[3:0]} - {1'b0, alu.b[3:0]}
                            - {4'h0, (alu.op == ALU_SUBX) & cin};
                        sum9 = {1'b0, alu.a[7:0]} - {1'b0, alu.b[7:0]}
                            - {8'h00, (alu.op == ALU_SUBX) & cin};
                        new_v = (alu.a[7] ^ alu.b[7]) & (alu.a[7] ^ res[7]);
                    end
                    else
                    begin
                        low5 = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]}
                            + {4'h0, (alu.op == ALU_ADDX) & cin};
                        sum9 = {1'b0, alu.a[7:0]} + {1'b0, alu.b[7:0]}
                            + {8'h00, (alu.op == ALU_ADDX) & cin};
                        new_v = ~(alu.a[7] ^ alu.b[7]) & (alu.a[7] ^ res[7]);
                    end
                    new_h = low5[4];
                    new_c = sum9[8];
                    upd_h = 1'b1;
                end
                else
                begin
                    if (is_sub)
                    begin
                        low13 = {1'b0, alu.a[11:0]} - {1'b0, alu.b[11:0]};
                        sum17 = {1'b0, alu.a} - {1'b0, alu.b};
                        new_v = (alu.a[15] ^ alu.b[15]) & (alu.a[15] ^ res[15]);
                    end
                    else
                    begin
                        low13 = {1'b0, alu.a[11:0]} + {1'b0, alu.b[11:0]};
                        sum17 = {1'b0, alu.a} + {1'b0, alu.b};
                        new_v = ~(alu.a[15] ^ alu.b[15]) & (alu.a[15] ^ res[15]);
                    end
                    new_h = low13[12];
                    new_c = sum17[16];
                    upd_h = 1'b1;
                end
                upd_n = 1'b1;
                upd_z = 1'b1;
                upd_v = 1'b1;
                upd_c = 1'b1;
            end
            ALU_LOGIC:
            begin
                upd_n = 1'b1;
                upd_z = 1'b1;
                upd_v = 1'b1;
            end
            ALU_SHIFT:
            begin
                new_c = cin;
                upd_n = 1'b1;
                upd_z = 1'b1;
                upd_v = 1'b1;
                upd_c = alu.carry_valid;
            end
            ALU_DAA, ALU_DAS:
            begin
                // Adjuster reads half_carry; carry is its decimal carry out
                new_c = cin;
                upd_n = 1'b1;
                upd_z = 1'b1;
                upd_c = 1'b1;
            end
            ALU_BITC:
            begin
                new_c = cin;
                upd_c = 1'b1;
            end
            default:
            begin
            end
        endcase
    end

    // Flag register next value; untouched bits hold
    always_comb
    begin
        flags_d = flags_q;
        unique case (flag_op)
            LOAD_FLAGS_OP: flags_d = flag_operand;
            AND_FLAGS_OP: flags_d = flags_q & flag_operand;
            OR_FLAGS_OP: flags_d = flags_q | flag_operand;
            XOR_FLAGS_OP: flags_d = flags_q ^ flag_operand;
            RESTORE_FLAGS_OP: flags_d = flag_restore_word[15:8];
            default:
            begin
                if (alu.en)
                begin
                    if (upd_h) flags_d[FLAG_HALF_BIT] = new_h;
                    if (upd_n) flags_d[FLAG_NEG_BIT] = new_n;
                    if (upd_z) flags_d[FLAG_ZERO_BIT] = new_z;
                    if (upd_v) flags_d[FLAG_OVF_BIT] = new_v;
                    if (upd_c) flags_d[FLAG_CARRY_BIT] = new_c;
                end
            end
        endcase
        // Exception entry wins over a software clear of the mask
        if (exception_start)
        begin
            flags_d[FLAG_MASK_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flags_q <= FLAGS_RESET;
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    assign condition_flags = flags_q;
    assign flags_push_word = {flags_q, flags_q};
    assign interrupts_masked = flags_q[FLAG_MASK_BIT];
    assign half_carry = flags_q[FLAG_HALF_BIT];

    // Branch condition decode over N, Z, V, C
    function automatic logic cond_eval(input logic [3:0] cc, input logic [7:0] f);
        logic n, z, v, c, r;
        n = f[FLAG_NEG_BIT];
        z = f[FLAG_ZERO_BIT];
        v = f[FLAG_OVF_BIT];
        c = f[FLAG_CARRY_BIT];
        unique case (cc[3:1])
            3'h0: r = 1'b1;
            3'h1: r = ~(c | z);
            3'h2: r = ~c;
            3'h3: r = ~z;
            3'h4: r = ~v;
            3'h5: r = ~n;
            3'h6: r = ~(n ^ v);
            default: r = ~(z | (n ^ v));
        endcase
        cond_eval = cc[0] ? ~r : r;
    endfunction

    assign branch_taken = cond_eval(branch_cond, flags_q);

    chk_mask_on_exc: assert property (
        @(posedge clk) disable iff (!reset_n)
        exception_start |=> condition_flags[FLAG_MASK_BIT])
        else $error("mask bit not set after exception start");

    chk_pc_even: assert property (
        @(posedge clk) disable iff (!reset_n)
        instruction_pointer[0] == 1'b0)
        else $error("program counter odd");

    sequence vec_fetch;
        vector_req && vector_valid;
    endsequence

    chk_vector_load: assert property (
        @(posedge clk) disable iff (!reset_n)
        vec_fetch |=> (instruction_pointer == word_align($past(vector_data))) && !vector_req)
        else $error("vector not loaded");

    chk_push_copy: assert property (
        @(posedge clk) disable iff (!reset_n)
        flags_push_word[15:8] == flags_push_word[7:0])
        else $error("pushed flag halves differ");

    chk_flags_hold: assert property (
        @(posedge clk) disable iff (!reset_n)
        (flag_op == FLAG_OP_NONE && !alu.en && !exception_start) |=> $stable(condition_flags))
        else $error("flags changed with no cause");

    chk_user_bits: assert property (
        @(posedge clk) disable iff (!reset_n)
        (flag_op == LOAD_FLAGS_OP) |=> (condition_flags[6] == $past(flag_operand[6]))
            && (condition_flags[4] == $past(flag_operand[4])))
        else $error("user bits not loaded");

    chk_zero_flag: assert property (
        @(posedge clk) disable iff (!reset_n)
        (alu.en && flag_op == FLAG_OP_NONE && alu.op == ALU_LOGIC && !alu.word)
            |=> condition_flags[FLAG_ZERO_BIT] == ($past(alu.result[7:0]) == 8'h00))
        else $error("zero flag wrong");

    chk_half_byte: assert property (
        @(posedge clk) disable iff (!reset_n)
        (alu.en && flag_op == FLAG_OP_NONE && alu.op == ALU_ADD && !alu.word)
            |=> condition_flags[FLAG_HALF_BIT]
            == (({1'b0, $past(alu.a[3:0])} + {1'b0, $past(alu.b[3:0])}) > 5'h0f))
        else $error("byte half carry wrong");

    chk_and_flags: assert property (
        @(posedge clk) disable iff (!reset_n)
        (flag_op == AND_FLAGS_OP && !exception_start)
            |=> condition_flags == ($past(condition_flags) & $past(flag_operand)))
        else $error("and of flags wrong");
endmodule

// ==== verif/core_model.sv ====
// Behavioural model of the core's arithmetic and vector fetch side
`timescale 1ns/1ps
module core_model
    import regfile_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] vec_wait,
    input wire logic [15:0] vec_word,
    input wire logic vector_req,
    input wire logic req_en,
    input wire alu_op_t req_op,
    input wire logic req_word,
    input wire logic [15:0] req_a,
    input wire logic [15:0] req_b,
    input wire logic req_cin,
    input wire logic req_cvalid,
    output alu_report_t alu,
    output logic [15:0] vector_data,
    output logic vector_valid
);
    logic [4:0] wait_cnt;
    logic [15:0] res;

    // Shift and bit results come in on b, as the datapath hands them over
    always_comb
    begin
        case (req_op)
            ALU_ADD, ALU_ADDX: res = req_a + req_b + {15'h0000, req_op == ALU_ADDX && req_cin};
            ALU_SUB, ALU_SUBX, ALU_CMP, ALU_NEG:
                res = req_a - req_b - {15'h0000, req_op == ALU_SUBX && req_cin};
            default: res = req_b;
        endcase
        if (!req_word)
        begin
            res[15:8] = 8'h00;
        end
    end

    assign alu = '{en: req_en, op: req_op, word: req_word, a: req_a, b: req_b,
                   result: res, carry_in_bit: req_cin, carry_valid: req_cvalid};

    // Vector word valid one cycle only; the data bus toggles outside it
    always_ff @(negedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wait_cnt <= 5'h00;
            vector_valid <= 1'b0;
            vector_data <= 16'h5a5a;
        end
        else if (vector_req && wait_cnt == {1'b0, vec_wait})
        begin
            wait_cnt <= wait_cnt + 5'h01;
            vector_valid <= 1'b1;
            vector_data <= vec_word;
        end
        else
        begin
            wait_cnt <= (vector_req && wait_cnt != 5'h1f) ? wait_cnt + 5'h01 : wait_cnt;
            vector_valid <= 1'b0;
            vector_data <= ~vector_data;
        end
    end
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the register file, program counter and flags
`timescale 1ns/1ps
module tb
    import regfile_pkg::*;
;
    logic clk, reset_n, pc_load, pc_advance, exception_start, vector_valid;
    logic req_en, req_word, req_cin, req_cvalid, vector_req;
    logic interrupts_masked, half_carry, branch_taken;
    logic [2:0] rd_a_pair, rd_b_pair, addr_pair;
    logic [3:0] vec_wait, branch_cond;
    logic [7:0] flag_operand, condition_flags;
    logic [15:0] pc_load_value, flag_restore_word, req_a, req_b, vector_data;
    logic [15:0] rd_a_data, rd_b_data, addr_out, stack_top_pointer;
    logic [15:0] instruction_pointer, vector_addr, flags_push_word;
    gpr_write_t gpr_wr;
    access_t rd_a_size, rd_b_size;
    flag_op_t flag_op;
    alu_op_t req_op;
    alu_report_t alu;
    int err_count = 0;
    int n_compared = 0;

    cpu_register_file_flags dut_u (.clk(clk), .reset_n(reset_n), .gpr_wr(gpr_wr),
        .rd_a_pair(rd_a_pair), .rd_a_size(rd_a_size), .rd_b_pair(rd_b_pair),
        .rd_b_size(rd_b_size), .addr_pair(addr_pair), .vector_data(vector_data),
        .vector_valid(vector_valid), .pc_load(pc_load), .pc_load_value(pc_load_value),
        .pc_advance(pc_advance), .exception_start(exception_start), .alu(alu),
        .flag_op(flag_op), .flag_operand(flag_operand),
        .flag_restore_word(flag_restore_word), .branch_cond(branch_cond),
        .rd_a_data(rd_a_data), .rd_b_data(rd_b_data), .addr_out(addr_out),
        .stack_top_pointer(stack_top_pointer), .instruction_pointer(instruction_pointer),
        .vector_addr(vector_addr), .vector_req(vector_req),
        .condition_flags(condition_flags), .flags_push_word(flags_push_word),
        .interrupts_masked(interrupts_masked), .half_carry(half_carry),
        .branch_taken(branch_taken));

    core_model model_u (.clk(clk), .reset_n(reset_n), .vec_wait(vec_wait),
        .vec_word(16'h0124), .vector_req(vector_req), .req_en(req_en), .req_op(req_op),
        .req_word(req_word), .req_a(req_a), .req_b(req_b), .req_cin(req_cin),
        .req_cvalid(req_cvalid), .alu(alu), .vector_data(vector_data),
        .vector_valid(vector_valid));

    initial
    begin
        clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2.0) clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask

    task automatic close_out;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Callers hold the strobe between calls so back-to-back edges stay legal
    task automatic wr(input logic [2:0] p, input access_t s, input logic [15:0] d);
        gpr_wr = '{en: 1'b1, pair: p, size: s, data: d};
        tick(1);
    endtask

    task automatic fop(input flag_op_t op, input logic [7:0] v);
        flag_op = op;
        flag_operand = v;
        tick(1);
    endtask

    task automatic alu_row(input alu_op_t op, input logic w, input logic [15:0] a,
                           input logic [15:0] b, input logic c, input logic [7:0] e);
        req_en = 1'b1;
        req_op = op;
        req_word = w;
        req_a = a;
        req_b = b;
        req_cin = c;
        req_cvalid = 1'b1;
        tick(1);
        chk(condition_flags, e);
    endtask

    function automatic logic exp_branch(input logic [3:0] f, input logic [3:0] c);
        logic r;
        case (c[3:1])
            3'h0: r = 1'b1;
            3'h1: r = !(f[0] | f[2]);
            3'h2: r = !f[0];
            3'h3: r = !f[2];
            3'h4: r = !f[1];
            3'h5: r = !f[3];
            3'h6: r = !(f[3] ^ f[1]);
            default: r = !(f[2] | (f[3] ^ f[1]));
        endcase
        return r ^ c[0];
    endfunction

    task automatic t_reset(input logic [3:0] w);
        reset_n = 1'b0;
        vec_wait = w;
        tick(8);
        chk(condition_flags, 8'h80);
        chk(vector_req, 1'b1);
        chk(instruction_pointer, 16'h0000);
        reset_n = 1'b1;
        pc_load = 1'b1;
        pc_load_value = 16'h4444;
        tick(1);
        pc_load = 1'b0;
        if (w > 4'h1)
            chk(instruction_pointer, 16'h0000);
        chk(vector_addr, 16'h0000);
        for (int i = 0; i < 20 && vector_req !== 1'b0; i++)
            tick(1);
        chk(vector_req, 1'b0);
        chk(instruction_pointer, 16'h0124);
        $display("reset test done");
    endtask

    task automatic t_gpr;
        logic [15:0] w [8];
        logic [15:0] eb;
        w[7] = 16'hfff0;
        wr(3'h7, ACC_WORD, w[7]);
        for (int p = 0; p < 7; p++)
        begin
            w[p] = {p[2:0], 5'h0a, p[2:0], 5'h15};
            wr(p[2:0], ACC_WORD, w[p]);
        end
        wr(3'h3, ACC_UPPER, 16'h00ab);
        wr(3'h4, ACC_LOWER, 16'h00cd);
        gpr_wr.en = 1'b0;
        w[3][15:8] = 8'hab;
        w[4][7:0] = 8'hcd;
        for (int p = 0; p < 8; p++)
        begin
            rd_a_pair = p[2:0];
            rd_b_pair = p[2:0];
            addr_pair = p[2:0];
            rd_b_size = p[0] ? ACC_UPPER : ACC_LOWER;
            tick(1);
            eb = p[0] ? {8'h00, w[p][15:8]} : {8'h00, w[p][7:0]};
            chk(rd_a_data, w[p]);
            chk(rd_b_data, eb);
            chk(addr_out, w[p]);
        end
        chk(stack_top_pointer, w[7]);
        $display("register test done");
    endtask

    task automatic t_flags;
        fop(LOAD_FLAGS_OP, 8'h5a);
        chk(condition_flags, 8'h5a);
        chk(flags_push_word, 16'h5a5a);
        chk({half_carry, interrupts_masked}, 2'b00);
        fop(AND_FLAGS_OP, 8'h3c);
        chk(condition_flags, 8'h18);
        fop(OR_FLAGS_OP, 8'ha1);
        chk(condition_flags, 8'hb9);
        chk({half_carry, interrupts_masked}, 2'b11);
        fop(XOR_FLAGS_OP, 8'hff);
        chk(condition_flags, 8'h46);
        flag_restore_word = 16'ha53c;
        fop(RESTORE_FLAGS_OP, 8'h00);
        chk(condition_flags, 8'ha5);
        exception_start = 1'b1;
        fop(AND_FLAGS_OP, 8'h00);
        exception_start = 1'b0;
        flag_op = FLAG_OP_NONE;
        chk(condition_flags, 8'h80);
        tick(1);
        chk(condition_flags, 8'h80);
        $display("flag test done");
    endtask

    task automatic t_alu;
        fop(LOAD_FLAGS_OP, 8'h50);
        flag_op = FLAG_OP_NONE;
        alu_row(ALU_ADD, 1'b0, 16'h000f, 16'h0001, 1'b0, 8'h70);
        alu_row(ALU_ADD, 1'b0, 16'h007f, 16'h0001, 1'b0, 8'h7a);
        alu_row(ALU_ADD, 1'b0, 16'h00ff, 16'h0001, 1'b0, 8'h75);
        alu_row(ALU_SUB, 1'b0, 16'h0000, 16'h0001, 1'b0, 8'h79);
        alu_row(ALU_CMP, 1'b0, 16'h0005, 16'h0005, 1'b0, 8'h54);
        alu_row(ALU_SHIFT, 1'b0, 16'h0000, 16'h0080, 1'b1, 8'h59);
        alu_row(ALU_ADD, 1'b1, 16'h0fff, 16'h0001, 1'b0, 8'h70);
        alu_row(ALU_SUB, 1'b1, 16'h8000, 16'h0001, 1'b0, 8'h72);
        alu_row(ALU_BITC, 1'b0, 16'h0000, 16'h0000, 1'b1, 8'h73);
        alu_row(ALU_BITC, 1'b0, 16'h0000, 16'h0000, 1'b0, 8'h72);
        alu_row(ALU_ADDX, 1'b0, 16'h000e, 16'h0001, 1'b1, 8'h70);
        alu_row(ALU_SUBX, 1'b0, 16'h0000, 16'h0000, 1'b1, 8'h79);
        alu_row(ALU_NEG, 1'b0, 16'h0000, 16'h0080, 1'b0, 8'h5b);
        alu_row(ALU_DAA, 1'b0, 16'h0000, 16'h0000, 1'b1, 8'h57);
        alu_row(ALU_LOGIC, 1'b0, 16'h0000, 16'h0000, 1'b0, 8'h55);
        flag_op = LOAD_FLAGS_OP;
        flag_operand = 8'h00;
        alu_row(ALU_ADD, 1'b0, 16'h007f, 16'h0001, 1'b0, 8'h00);
        flag_op = FLAG_OP_NONE;
        req_en = 1'b0;
        $display("arithmetic test done");
    endtask

    task automatic t_branch;
        for (int f = 0; f < 16; f++)
        begin
            fop(LOAD_FLAGS_OP, {4'h0, f[3:0]});
            flag_op = FLAG_OP_NONE;
            for (int c = 0; c < 16; c++)
            begin
                branch_cond = c[3:0];
                tick(1);
                chk(branch_taken, exp_branch(f[3:0], c[3:0]));
            end
        end
        $display("branch test done");
    endtask

    task automatic t_pc;
        pc_load = 1'b1;
        pc_load_value = 16'h2469;
        pc_advance = 1'b1;
        tick(1);
        chk(instruction_pointer, 16'h2468);
        pc_load = 1'b0;
        tick(1);
        chk(instruction_pointer, 16'h246a);
        pc_load = 1'b1;
        pc_load_value = 16'hffff;
        pc_advance = 1'b0;
        tick(1);
        chk(instruction_pointer, 16'hfffe);
        pc_load = 1'b0;
        pc_advance = 1'b1;
        tick(1);
        pc_advance = 1'b0;
        chk(instruction_pointer, 16'h0000);
        $display("counter test done");
    endtask

    initial
    begin
        gpr_wr = '0;
        {rd_a_pair, rd_b_pair, addr_pair} = '0;
        rd_a_size = ACC_WORD;
        rd_b_size = ACC_WORD;
        {pc_load, pc_advance, exception_start, req_en, req_word, req_cin, req_cvalid} = '0;
        {pc_load_value, flag_restore_word, req_a, req_b} = '0;
        flag_op = FLAG_OP_NONE;
        flag_operand = 8'h00;
        branch_cond = 4'h0;
        req_op = ALU_NONE;
        t_reset(4'h3);
        t_gpr();
        t_flags();
        t_alu();
        t_branch();
        t_pc();
        t_reset(4'h0);
        close_out();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (3000) @(posedge clk);
        err_count++;
        close_out();
    end
endmodule
